// File: hw/timer_route_pkg.sv
// Package with register offsets, reset values and field positions for the timer pin routing block.
package timer_route_pkg;

    // Register byte addresses in the special function register space.
    localparam logic [15:0] PORT3_DIRECTION_ADDR  = 16'hff23;
    localparam logic [15:0] PORT12_DIRECTION_ADDR = 16'hff2c;
    localparam logic [15:0] TIMER_PIN_SELECT_ADDR = 16'hff39;
    localparam logic [15:0] TIMER_MODE_ADDR       = 16'hff80;
    localparam logic [15:0] UP_COUNTER_ADDR       = 16'hff82;
    localparam logic [15:0] PRIMARY_COMPARE_ADDR  = 16'hff84;
    localparam logic [15:0] SECONDARY_COMPARE_ADDR = 16'hff86;
    localparam logic [15:0] PRESCALER_SELECT_ADDR = 16'hff88;

    // Values after reset.
    localparam logic [7:0]  PORT_DIR_RESET        = 8'hff;
    localparam logic [7:0]  PIN_SELECT_RESET      = 8'h00;
    localparam logic [7:0]  TIMER_MODE_RESET      = 8'h00;
    localparam logic [7:0]  PRESCALER_RESET       = 8'h00;
    localparam logic [15:0] COUNTER_RESET         = 16'h0000;
    localparam logic [15:0] COMPARE_RESET         = 16'hffff;

    // Implemented bit masks of the port direction registers.
    localparam logic [7:0]  PORT3_DIR_IMPL        = 8'h1f;
    localparam logic [7:0]  PORT12_DIR_IMPL       = 8'h06;

    // Field positions in the pin selection register.
    localparam int          TOGGLE_OUT_ROUTE_BIT  = 0;
    localparam int          CAPTURE_IN_ROUTE_BIT  = 1;
    localparam int          EVENT_IN_ROUTE_LO_BIT = 4;
    localparam int          EXT_IRQ_ROUTE_LO_BIT  = 6;
    localparam logic [7:0]  PIN_SELECT_IMPL       = 8'hf3;

    // Field position of the operating mode bits in the mode register.
    localparam int          OP_MODE_LO_BIT        = 2;

    // Operating mode codes.
    typedef enum logic [1:0] {
        MODE_STOP     = 2'b00,
        MODE_RSVD_01  = 2'b01,
        MODE_RSVD_10  = 2'b10,
        MODE_INTERVAL = 2'b11
    } op_mode_t;

    // Event input routing codes.
    localparam logic [1:0]  EVENT_ROUTE_DEFAULT   = 2'b00;
    localparam logic [1:0]  EVENT_ROUTE_P12_1     = 2'b01;
    localparam logic [1:0]  EVENT_ROUTE_P12_5     = 2'b10;

    // Count clock dividers, as shift amounts of the core clock.
    localparam int          DIV_SEL1_LOG2         = 2;
    localparam int          DIV_SEL2_LOG2         = 8;
    localparam int          PRESCALE_WIDTH        = 8;

endpackage

// File: hw/timer_pin_routing_interval_mode.sv
// Timer pin routing, port direction registers and interval mode counter.
// How it works
// [RQ1] Pin selection register clears to zero on reset, selecting default pins.
// [RQ2] Pin selection register takes single-bit writes as well as byte writes.
// [RQ3] Event routing code 00 default, 01 port 12 pin 1, 10 port 12 pin 5.
// [RQ4] Capture routing bit 0 selects default pin, 1 selects port 3 pin 2.
// [RQ5] Output routing bit 0 selects default pin, 1 drives port 3 pin 1.
// [RQ6] Port 3 direction bits 0 to 4: 0 enables output buffer, 1 disables it.
// [RQ7] Port 12 direction has only bits 1 and 2; other bits read as one.
// [RQ8] Both direction registers reset to all ones, every pin an input.
// [RQ9] Software clears direction and latch of port 3 pin 1 for timer output.
// [RQ10] Software sets port 3 pin 2 and port 12 pin 1 to input for timer use.
// [RQ11] Event input on port 12 pin 5 reaches the timer whatever the port settings.
// [RQ12] Software clears direction and latch of port 3 pin 4 for output.
// [RQ13] Software sets port 3 pins 3 and 4 to input for timer inputs.
// [RQ14] Mode 11 starts counting in step with the count clock.
// [RQ15] Counter equal to primary compare clears to zero and raises primary match.
// [RQ16] Reading the counter register returns the current count.
// [RQ17] Software leaves output control at zero for plain interval operation.
// [RQ18] Software clears edge bits and picks count clock with two low bits.
// [RQ19] Match interval is compare value plus one count clock periods.
// [RQ20] Secondary compare equal to counter raises its own match interrupt.
// [RQ21] Mode 00 stops counting and returns the counter to zero.
// [RQ22] Each timer signal touches only the pin its selection field names.
// [RQ23] Counter wraps at maximum without a match and keeps counting in mode 11.
`timescale 1ns/1ps
`default_nettype none

module timer_pin_routing_interval_mode
    import timer_route_pkg::*;
(
    // Clock and reset.
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    // Register access port.
    input  wire logic [15:0] i_reg_addr,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_bit_wr,
    input  wire logic [2:0]  i_reg_bit_pos,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_reg_hi_byte,
    output logic      [7:0]  o_reg_rdata,
    // Pin inputs from the pads.
    input  wire logic        i_pin_default_event,
    input  wire logic        i_pin_p12_1,
    input  wire logic        i_pin_p12_5,
    input  wire logic        i_pin_default_capture,
    input  wire logic        i_pin_p3_2,
    // Port output latches from the port block, and the timer toggle level.
    input  wire logic [4:0]  i_port3_latch,
    input  wire logic        i_toggle_level,
    // Pin outputs and buffer enables.
    output logic      [4:0]  o_port3_out,
    output logic      [4:0]  o_port3_oe,
    output logic      [1:0]  o_port12_oe,
    output logic             o_default_toggle_out,
    // Routed timer inputs and interrupts.
    output logic             o_event_capture_input,
    output logic             o_secondary_capture_input,
    output logic             o_primary_match_irq,
    output logic             o_secondary_match_irq
);

    // Register state.
    logic [7:0]  port3_direction_reg,  port3_direction_next;
    logic [7:0]  port12_direction_reg, port12_direction_next;
    logic [7:0]  timer_pin_select_reg, timer_pin_select_next;
    logic [7:0]  timer_mode_reg,       timer_mode_next;
    logic [7:0]  prescaler_reg,        prescaler_next;
    logic [15:0] primary_compare_reg,  primary_compare_next;
    logic [15:0] secondary_compare_reg, secondary_compare_next;
    logic [15:0] up_counter_reg,       up_counter_next;
    logic [PRESCALE_WIDTH-1:0] prescale_reg, prescale_next;
    logic        primary_irq_reg,      primary_irq_next;
    logic        secondary_irq_reg,    secondary_irq_next;
    // Synchroniser stages for pad inputs.
    logic [4:0]  pin_sync1_reg, pin_sync2_reg;

    op_mode_t    op_mode;
    logic [1:0]  event_route;
    logic        count_tick;

    // Merge a write into a register, either one bit or the whole byte.
    function automatic logic [7:0] merge_write(input logic [7:0] cur, input logic bit_wr,
                                               input logic [2:0] pos, input logic [7:0] wd);
        logic [7:0] res;
        res = cur;
        if (bit_wr) begin
            res[pos] = wd[0];
        end else begin
            res = wd;
        end
        return res;
    endfunction

    // Merge one byte into a sixteen-bit register.
    function automatic logic [15:0] merge_half(input logic [15:0] cur, input logic hi,
                                               input logic [7:0] wd);
        return hi ? {wd, cur[7:0]} : {cur[15:8], wd};
    endfunction

    assign op_mode     = op_mode_t'(timer_mode_reg[OP_MODE_LO_BIT +: 2]);
    assign event_route = timer_pin_select_reg[EVENT_IN_ROUTE_LO_BIT +: 2];

    // Two-flip-flop synchronisers; the first stage feeds only the second.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_sync1_reg <= 5'h0;
            pin_sync2_reg <= 5'h0;
        end else begin
            pin_sync1_reg <= {i_pin_default_event, i_pin_p12_1, i_pin_p12_5,
                              i_pin_default_capture, i_pin_p3_2};
            pin_sync2_reg <= pin_sync1_reg;
        end
    end

    // Register writes; unimplemented bits are forced so they always read back fixed.
    always_comb begin
        port3_direction_next   = port3_direction_reg;
        port12_direction_next  = port12_direction_reg;
        timer_pin_select_next  = timer_pin_select_reg;
        timer_mode_next        = timer_mode_reg;
        prescaler_next         = prescaler_reg;
        primary_compare_next   = primary_compare_reg;
        secondary_compare_next = secondary_compare_reg;
        if (i_reg_wr) begin
            unique case (i_reg_addr)
                PORT3_DIRECTION_ADDR: begin
                    port3_direction_next = merge_write(port3_direction_reg, i_reg_bit_wr,
                        i_reg_bit_pos, i_reg_wdata) | ~PORT3_DIR_IMPL; // [RQ6]
                end
                PORT12_DIRECTION_ADDR: begin
                    port12_direction_next = merge_write(port12_direction_reg, i_reg_bit_wr,
                        i_reg_bit_pos, i_reg_wdata) | ~PORT12_DIR_IMPL; // [RQ7]
                end
                TIMER_PIN_SELECT_ADDR: begin
                    timer_pin_select_next = merge_write(timer_pin_select_reg, i_reg_bit_wr,
                        i_reg_bit_pos, i_reg_wdata) & PIN_SELECT_IMPL; // [RQ2]
                end
                TIMER_MODE_ADDR: begin
                    timer_mode_next = merge_write(timer_mode_reg, i_reg_bit_wr,
                        i_reg_bit_pos, i_reg_wdata);
                end
                PRESCALER_SELECT_ADDR: begin
                    prescaler_next = merge_write(prescaler_reg, i_reg_bit_wr,
                        i_reg_bit_pos, i_reg_wdata);
                end
                PRIMARY_COMPARE_ADDR: begin
                    primary_compare_next = merge_half(primary_compare_reg,
                        i_reg_hi_byte, i_reg_wdata);
                end
                SECONDARY_COMPARE_ADDR: begin
                    secondary_compare_next = merge_half(secondary_compare_reg,
                        i_reg_hi_byte, i_reg_wdata);
                end
                default: begin
                end
            endcase
        end
    end

    // Register file storage.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            port3_direction_reg   <= PORT_DIR_RESET; // [RQ8]
            port12_direction_reg  <= PORT_DIR_RESET; // [RQ8]
            timer_pin_select_reg  <= PIN_SELECT_RESET; // [RQ1]
            timer_mode_reg        <= TIMER_MODE_RESET;
            prescaler_reg         <= PRESCALER_RESET;
            primary_compare_reg   <= COMPARE_RESET;
            secondary_compare_reg <= COMPARE_RESET;
        end else begin
            port3_direction_reg   <= port3_direction_next;
            port12_direction_reg  <= port12_direction_next;
            timer_pin_select_reg  <= timer_pin_select_next;
            timer_mode_reg        <= timer_mode_next;
            prescaler_reg         <= prescaler_next;
            primary_compare_reg   <= primary_compare_next;
            secondary_compare_reg <= secondary_compare_next;
        end
    end

    // Count clock enable from the prescaler; the free-running divider is
    // held cleared while stopped so the first count lands on a clean tick.
    always_comb begin
        prescale_next = (op_mode == MODE_STOP) ? '0 : prescale_reg + 1'b1;
        unique case (prescaler_reg[1:0])
            2'b00: count_tick = 1'b1;
            2'b01: count_tick = (prescale_reg[DIV_SEL1_LOG2-1:0] == '1);
            2'b10: count_tick = (prescale_reg == '1);
            2'b11: count_tick = 1'b0; // External edge counting is not built here.
        endcase
        if (op_mode != MODE_INTERVAL) begin
            count_tick = 1'b0;
        end
    end

    // Interval counter with compare match; the match is judged on the count
    // clock so the period is the compare value plus one ticks.
    always_comb begin
        up_counter_next    = up_counter_reg;
        primary_irq_next   = 1'b0;
        secondary_irq_next = 1'b0;
        if (op_mode == MODE_STOP) begin
            up_counter_next = COUNTER_RESET; // [RQ21]
        end else if (count_tick) begin // [RQ14]
            if (up_counter_reg == primary_compare_reg) begin
                up_counter_next  = COUNTER_RESET; // [RQ15] [RQ19]
                primary_irq_next = 1'b1; // [RQ15]
            end else begin
                up_counter_next = up_counter_reg + 16'h0001; // [RQ23]
            end
            secondary_irq_next = (up_counter_reg == secondary_compare_reg); // [RQ20]
        end
    end

    // Counter and interrupt pulse storage.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            up_counter_reg    <= COUNTER_RESET;
            prescale_reg      <= '0;
            primary_irq_reg   <= 1'b0;
            secondary_irq_reg <= 1'b0;
        end else begin
            up_counter_reg    <= up_counter_next;
            prescale_reg      <= prescale_next;
            primary_irq_reg   <= primary_irq_next;
            secondary_irq_reg <= secondary_irq_next;
        end
    end

    // Read data multiplexer; unmapped addresses read as zero.
    always_comb begin
        unique case (i_reg_addr)
            PORT3_DIRECTION_ADDR:   o_reg_rdata = port3_direction_reg;
            PORT12_DIRECTION_ADDR:  o_reg_rdata = port12_direction_reg; // [RQ7]
            TIMER_PIN_SELECT_ADDR:  o_reg_rdata = timer_pin_select_reg;
            TIMER_MODE_ADDR:        o_reg_rdata = timer_mode_reg;
            PRESCALER_SELECT_ADDR:  o_reg_rdata = prescaler_reg;
            UP_COUNTER_ADDR: begin
                o_reg_rdata = i_reg_hi_byte ? up_counter_reg[15:8]
                                            : up_counter_reg[7:0]; // [RQ16]
            end
            PRIMARY_COMPARE_ADDR: begin
                o_reg_rdata = i_reg_hi_byte ? primary_compare_reg[15:8]
                                            : primary_compare_reg[7:0];
            end
            SECONDARY_COMPARE_ADDR: begin
                o_reg_rdata = i_reg_hi_byte ? secondary_compare_reg[15:8]
                                            : secondary_compare_reg[7:0];
            end
            default:                o_reg_rdata = 8'h00;
        endcase
    end

    // Input routing: every pad is synchronised, only the selected pin is passed on. Port 12 pin 5 is taken
    // straight from the pad, bypassing direction and latch.
    always_comb begin
        unique case (event_route)
            EVENT_ROUTE_P12_1: o_event_capture_input = pin_sync2_reg[3]; // [RQ3]
            EVENT_ROUTE_P12_5: o_event_capture_input = pin_sync2_reg[2]; // [RQ3] [RQ11]
            default:           o_event_capture_input = pin_sync2_reg[4]; // [RQ3] [RQ22]
        endcase
        o_secondary_capture_input = timer_pin_select_reg[CAPTURE_IN_ROUTE_BIT]
            ? pin_sync2_reg[0] : pin_sync2_reg[1]; // [RQ4] [RQ22]
    end

    // Output routing and buffer enables; the timer only owns port 3 pin 1 when
    // routed there, otherwise that pin carries its latch as a plain port.
    always_comb begin
        o_port3_oe  = ~port3_direction_reg[4:0]; // [RQ6]
        o_port12_oe = ~port12_direction_reg[2:1]; // [RQ7]
        o_port3_out = i_port3_latch;
        if (timer_pin_select_reg[TOGGLE_OUT_ROUTE_BIT]) begin
            o_port3_out[1] = i_toggle_level & ~i_port3_latch[1]; // [RQ5] [RQ9]
        end
        o_default_toggle_out = timer_pin_select_reg[TOGGLE_OUT_ROUTE_BIT]
            ? 1'b0 : i_toggle_level; // [RQ5] [RQ22]
    end

    assign o_primary_match_irq   = primary_irq_reg;
    assign o_secondary_match_irq = secondary_irq_reg;

endmodule

`default_nettype wire

// File: verification/timer_route_checker.sv
// Port-level assertions for the timer pin routing and interval mode block.
`timescale 1ns/1ps
`default_nettype none

module timer_route_checker
    import timer_route_pkg::*;
(
    // Clock and reset.
    input wire logic        i_core_clk,
    input wire logic        i_rst_n,
    // Register access port.
    input wire logic [15:0] i_reg_addr,
    input wire logic        i_reg_wr,
    input wire logic        i_reg_bit_wr,
    input wire logic [2:0]  i_reg_bit_pos,
    input wire logic [7:0]  i_reg_wdata,
    input wire logic [7:0]  o_reg_rdata,
    // Pads, latches and toggle level.
    input wire logic        i_pin_default_event,
    input wire logic        i_pin_p12_1,
    input wire logic        i_pin_p12_5,
    input wire logic        i_pin_default_capture,
    input wire logic        i_pin_p3_2,
    input wire logic [4:0]  i_port3_latch,
    input wire logic        i_toggle_level,
    // Outputs under watch.
    input wire logic [4:0]  o_port3_out,
    input wire logic [4:0]  o_port3_oe,
    input wire logic [1:0]  o_port12_oe,
    input wire logic        o_default_toggle_out,
    input wire logic        o_event_capture_input,
    input wire logic        o_secondary_capture_input,
    input wire logic        o_primary_match_irq,
    input wire logic        o_secondary_match_irq
);
    logic [7:0] sel_reg;
    logic [7:0] sel_next;
    logic       ev_pin;
    logic       cap_pin;

    // Shadow of the pin selection register, rebuilt from the write strobes alone.
    always_comb begin
        sel_next = sel_reg;
        if (i_reg_wr && i_reg_addr == TIMER_PIN_SELECT_ADDR) begin
            if (i_reg_bit_wr) sel_next[i_reg_bit_pos] = i_reg_wdata[0];
            else sel_next = i_reg_wdata;
        end
        sel_next = sel_next & PIN_SELECT_IMPL;
    end

    // The shadow clears with the device, so it never drifts after a reset.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) sel_reg <= 8'h00;
        else sel_reg <= sel_next;
    end

    // Pad that each routing field names; the unused event code falls back to default.
    always_comb begin
        case (sel_reg[5:4])
            EVENT_ROUTE_P12_1: ev_pin = i_pin_p12_1;
            EVENT_ROUTE_P12_5: ev_pin = i_pin_p12_5;
            default:           ev_pin = i_pin_default_event;
        endcase
        cap_pin = sel_reg[CAPTURE_IN_ROUTE_BIT] ? i_pin_p3_2 : i_pin_default_capture;
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    // Routing and reset quiet through both synchroniser stages.
    sequence route_settled;
        sel_reg == $past(sel_reg) && sel_reg == $past(sel_reg, 2) && $past(i_rst_n) && $past(i_rst_n, 2);
    endsequence

    // A whole-byte write that puts the counter in stop mode.
    sequence stop_write;
        i_reg_wr && i_reg_addr == TIMER_MODE_ADDR && !i_reg_bit_wr && i_reg_wdata[3:2] == 2'b00;
    endsequence

    a_dir_reset: assert property ($rose(i_rst_n) |-> o_port3_oe == 5'h00 && o_port12_oe == 2'b00)
        else $error("output buffers not off after reset");
    a_p3_dir_map: assert property (i_reg_addr == PORT3_DIRECTION_ADDR |->
        o_reg_rdata[7:5] == 3'b111 && o_port3_oe == ~o_reg_rdata[4:0])
        else $error("port 3 buffers disagree with direction bits");
    a_p12_dir_map: assert property (i_reg_addr == PORT12_DIRECTION_ADDR |->
        {o_reg_rdata[7:3], o_reg_rdata[0]} == 6'h3f && o_port12_oe == ~o_reg_rdata[2:1])
        else $error("port 12 direction bits wrong");
    a_sel_mirror: assert property (i_reg_addr == TIMER_PIN_SELECT_ADDR |-> o_reg_rdata == sel_reg)
        else $error("pin selection register holds a wrong value");
    a_out_routed: assert property (sel_reg[TOGGLE_OUT_ROUTE_BIT] |-> !o_default_toggle_out &&
        o_port3_out[1] == (i_toggle_level & ~i_port3_latch[1]))
        else $error("routed toggle output wrong");
    a_out_default: assert property (!sel_reg[TOGGLE_OUT_ROUTE_BIT] |->
        o_default_toggle_out == i_toggle_level && o_port3_out == i_port3_latch)
        else $error("toggle output leaks onto port 3");
    a_event_route: assert property (route_settled |-> o_event_capture_input == $past(ev_pin, 2))
        else $error("event input taken from the wrong pad");
    a_capture_route: assert property (route_settled |-> o_secondary_capture_input == $past(cap_pin, 2))
        else $error("capture input taken from the wrong pad");
    a_prim_pulse: assert property (o_primary_match_irq |=> !o_primary_match_irq)
        else $error("primary match pulse longer than one cycle");
    a_sec_pulse: assert property (o_secondary_match_irq |=> !o_secondary_match_irq)
        else $error("secondary match pulse longer than one cycle");
    a_stop_quiet: assert property (stop_write |=> ##1 !o_primary_match_irq [*8])
        else $error("match pulse after the counter was stopped");
endmodule

bind timer_pin_routing_interval_mode timer_route_checker u_checker (.*);
`default_nettype wire

// File: verification/timer_pad_partner.sv
// Model of the outside sources at the timer's input pads.
`timescale 1ns/1ps
`default_nettype none

module timer_pad_partner (
    // Levels the outside sources put on the pads.
    input  wire logic [4:0] i_src,
    // Device drive of port 3.
    input  wire logic [4:0] i_port3_out,
    input  wire logic [4:0] i_port3_oe,
    // Pad levels seen by the device.
    output logic            o_pin_default_event,
    output logic            o_pin_p12_1,
    output logic            o_pin_p12_5,
    output logic            o_pin_default_capture,
    output logic            o_pin_p3_2
);
    // Sources drive the pads directly; only port 3 pin 2 follows the device instead, while the device drives it.
    always_comb begin
        o_pin_default_event   = i_src[0];
        o_pin_p12_1           = i_src[1];
        o_pin_p12_5           = i_src[2];
        o_pin_default_capture = i_src[3];
        o_pin_p3_2            = i_port3_oe[2] ? i_port3_out[2] : i_src[4];
    end
endmodule
`default_nettype wire

// File: verification/test_timer_pin_routing_interval_mode.sv
// Self-checking testbench for the timer pin routing and interval mode block.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            n_errors++; \
            $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); \
        end \
    end

module test_timer_pin_routing_interval_mode import timer_route_pkg::*;;
    logic        i_core_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic [15:0] i_reg_addr = 16'h0000;
    logic        i_reg_wr = 1'b0;
    logic        i_reg_bit_wr = 1'b0;
    logic [2:0]  i_reg_bit_pos = 3'd0;
    logic [7:0]  i_reg_wdata = 8'h00;
    logic        i_reg_hi_byte = 1'b0;
    logic [4:0]  i_port3_latch = 5'h00;
    logic        i_toggle_level = 1'b0;
    logic [4:0]  src = 5'h00;
    logic [7:0]  o_reg_rdata;
    logic [4:0]  o_port3_out, o_port3_oe;
    logic [1:0]  o_port12_oe;
    logic        o_default_toggle_out, o_event_capture_input, o_secondary_capture_input;
    logic        o_primary_match_irq, o_secondary_match_irq;
    logic        i_pin_default_event, i_pin_p12_1, i_pin_p12_5, i_pin_default_capture, i_pin_p3_2;
    int          n_errors = 0;
    int          num_checks = 0;
    int          n;
    int          s;

    timer_pin_routing_interval_mode DUT (.*);

    timer_pad_partner pads (
        .i_src                 (src),
        .i_port3_out           (o_port3_out),
        .i_port3_oe            (o_port3_oe),
        .o_pin_default_event   (i_pin_default_event),
        .o_pin_p12_1           (i_pin_p12_1),
        .o_pin_p12_5           (i_pin_p12_5),
        .o_pin_default_capture (i_pin_default_capture),
        .o_pin_p3_2            (i_pin_p3_2)
    );

    // Core clock at 20 MHz.
    initial begin
        forever #25 i_core_clk = ~i_core_clk;
    end

    // One register write, byte or single bit, held for exactly one edge.
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic hi = 1'b0,
                      input logic b = 1'b0, input logic [2:0] p = 3'd0);
        @(posedge i_core_clk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_hi_byte <= hi;
        i_reg_bit_wr <= b;
        i_reg_bit_pos <= p;
        i_reg_wr <= 1'b1;
        @(posedge i_core_clk);
        i_reg_wr <= 1'b0;
    endtask

    // Reads are combinational, so the address is parked and the data settles.
    task automatic rd(input logic [15:0] a, input logic hi = 1'b0);
        @(posedge i_core_clk);
        i_reg_addr <= a;
        i_reg_hi_byte <= hi;
        #10;
    endtask

    // Counts cycles to the next primary match and the secondary matches seen meanwhile.
    task automatic wait_irq(output int cycles, output int sec);
        cycles = 0;
        sec = 0;
        do begin
            @(posedge i_core_clk);
            #1;
            cycles++;
            if (o_secondary_match_irq === 1'b1) sec++;
        end while (o_primary_match_irq !== 1'b1 && cycles < 70000);
        if (cycles >= 70000) begin
            n_errors++;
            tally_and_finish();
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Main sequence: reset values, directions, routing, then interval counting.
    initial begin
        repeat (2) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        rd(TIMER_PIN_SELECT_ADDR);
        `CHK(o_reg_rdata, 8'h00)
        rd(PORT3_DIRECTION_ADDR);
        `CHK(o_reg_rdata, 8'hff)
        rd(PORT12_DIRECTION_ADDR);
        `CHK(o_reg_rdata, 8'hff)
        `CHK({o_port3_oe, o_port12_oe}, 7'h00)
        rd(16'hff00);
        `CHK(o_reg_rdata, 8'h00)
        wr(PORT3_DIRECTION_ADDR, 8'h00);
        wr(PORT12_DIRECTION_ADDR, 8'h00);
        rd(PORT3_DIRECTION_ADDR);
        `CHK(o_reg_rdata, 8'he0)
        `CHK(o_port3_oe, 5'h1f)
        rd(PORT12_DIRECTION_ADDR);
        `CHK(o_reg_rdata, 8'hf9)
        // Timer pin setup: port 3 pin 1 an output, pin 2 and port 12 pin 1 inputs.
        wr(PORT3_DIRECTION_ADDR, 8'h1d);
        wr(PORT12_DIRECTION_ADDR, 8'h01, 1'b0, 1'b1, 3'd1);
        rd(PORT12_DIRECTION_ADDR);
        `CHK({o_port3_oe, o_port12_oe}, 7'h0a)
        // Each event code by bit writes; the named pad opposes the other two event pads.
        for (int c = 0; c < 3; c++) begin
            wr(TIMER_PIN_SELECT_ADDR, {7'h00, c[0]}, 1'b0, 1'b1, 3'd4);
            wr(TIMER_PIN_SELECT_ADDR, {7'h00, c[1]}, 1'b0, 1'b1, 3'd5);
            for (int v = 0; v < 2; v++) begin
                @(posedge i_core_clk);
                src <= v[0] ? (5'h01 << c) : (5'h07 ^ (5'h01 << c));
                repeat (3) @(posedge i_core_clk);
                #1;
                `CHK(o_event_capture_input, v[0])
            end
        end
        // Capture and toggle output moved to port 3; reserved bits stay clear.
        wr(TIMER_PIN_SELECT_ADDR, 8'hcf);
        @(posedge i_core_clk);
        src <= 5'h10;
        i_toggle_level <= 1'b1;
        i_port3_latch <= 5'h15;
        rd(TIMER_PIN_SELECT_ADDR);
        `CHK(o_reg_rdata, 8'hc3)
        repeat (2) @(posedge i_core_clk);
        #1;
        `CHK(o_secondary_capture_input, 1'b1)
        `CHK({o_port3_out, o_default_toggle_out}, 6'h2e)
        wr(TIMER_PIN_SELECT_ADDR, 8'h00, 1'b0, 1'b1, 3'd0);
        #1;
        `CHK({o_port3_out, o_default_toggle_out}, 6'h2b)
        // Interval mode with compare 5 and secondary compare 2 at the full core rate.
        wr(PRIMARY_COMPARE_ADDR, 8'h05);
        wr(PRIMARY_COMPARE_ADDR, 8'h00, 1'b1);
        wr(SECONDARY_COMPARE_ADDR, 8'h02);
        wr(SECONDARY_COMPARE_ADDR, 8'h00, 1'b1);
        wr(PRESCALER_SELECT_ADDR, 8'h00);
        wr(TIMER_MODE_ADDR, 8'h0c);
        rd(UP_COUNTER_ADDR);
        wait_irq(n, s);
        `CHK(o_reg_rdata, 8'h00)
        for (int k = 0; k < 3; k++) begin
            wait_irq(n, s);
            `CHK(n, 6)
            `CHK(s, 1)
        end
        repeat (3) @(posedge i_core_clk);
        #1;
        `CHK(o_reg_rdata, 8'h03)
        wr(TIMER_MODE_ADDR, 8'h00);
        rd(UP_COUNTER_ADDR);
        repeat (4) @(posedge i_core_clk);
        #1;
        `CHK(o_reg_rdata, 8'h00)
        // Compare lowered below the running count, so the counter must wrap first.
        wr(PRIMARY_COMPARE_ADDR, 8'h01, 1'b1);
        wr(TIMER_MODE_ADDR, 8'h0c);
        repeat (8) @(posedge i_core_clk);
        wr(PRIMARY_COMPARE_ADDR, 8'h00, 1'b1);
        wait_irq(n, s);
        `CHK(n inside {[65000:65600]}, 1'b1)
        tally_and_finish();
    end
endmodule
`default_nettype wire
